// [hdl/rdcb_map.vh]
`ifndef RDCB_MAP_VH
`define RDCB_MAP_VH
// Register byte addresses
`define RDCB_ADDR_TALLY 8'hA0
`define RDCB_ADDR_CMD 8'hA4
`define RDCB_ADDR_DATA 8'hA8
`define RDCB_ADDR_CFG 8'hAC
`define RDCB_ADDR_IRQ_STAT 8'hB4
`define RDCB_ADDR_IRQ_EN 8'hB8
`define RDCB_ADDR_IRQ_CLR 8'hBC
// Command register fields
`define RDCB_CMD_BUSY 31
`define RDCB_CMD_DIR 30
`define RDCB_CMD_IDX_HI 7
// Flow configuration fields
`define RDCB_CFG_HI_MSB 23
`define RDCB_CFG_HI_LSB 16
`define RDCB_CFG_LO_MSB 15
`define RDCB_CFG_LO_LSB 8
`define RDCB_CFG_DUR_MSB 7
`define RDCB_CFG_DUR_LSB 4
`define RDCB_CFG_MULT 3
`define RDCB_CFG_BRD 2
`define RDCB_CFG_ADDR 1
`define RDCB_CFG_ANY 0
`define RDCB_CFG_MASK 32'h00FFFFFF
// Interrupt status bits
`define RDCB_IRQ_HALF 0
`define RDCB_IRQ_DONE 1
`define RDCB_IRQ_W 2
// Reset values
`define RDCB_RST_ZERO 32'h00000000
// Timing
`define RDCB_CLK_MHZ 50
`define RDCB_STEP_NS 100
`define RDCB_STEP_CYC ((`RDCB_STEP_NS * `RDCB_CLK_MHZ) / 1000)
`define RDCB_STEP_US 5
`define RDCB_STEP_US_CYC (`RDCB_STEP_US * `RDCB_CLK_MHZ)
`endif

// [hdl/rdcb_jam_time.v]
`timescale 1ns/1ns
`include "rdcb_map.vh"
module rdcb_jam_time
(
  // Clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // Control
  input wire start_i,
  input wire [3:0] sel_i,
  input wire speed100_i,
  // Status
  output reg active_o
);
  ////////////////////////////////////////////////////////////////////
  // Duration in 100 ns steps: 100M table, plus 2.2 us at 10M
  reg [15:0] steps;
  reg [15:0] base;
  reg [15:0] step_left;
  reg [7:0] pre;

  always @*
  begin
    case (sel_i)
      4'h0: base = 16'h0032;
      4'h1: base = 16'h0064;
      4'h2: base = 16'h0096;
      4'h3: base = 16'h00FA;
      default: base = 16'h01F4 * ({12'h000, sel_i} - 16'h0003);
    endcase
    steps = speed100_i ? base : base + 16'h0016;
  end

  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      active_o <= 1'b0;
      step_left <= 16'h0000;
      pre <= 8'h00;
    end
    else if (start_i)
    begin
      active_o <= 1'b1;
      step_left <= steps;
      pre <= 8'h00;
    end
    else if (active_o)
    begin
      if (pre == `RDCB_STEP_CYC - 1)
      begin
        pre <= 8'h00;
        if (step_left == 16'h0001)
          active_o <= 1'b0;
        step_left <= step_left - 16'h0001;
      end
      else
        pre <= pre + 8'h01;
    end
  end
endmodule // rdcb_jam_time

// [hdl/rdcb_top.v]
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "rdcb_map.vh"
module rdcb_top
(
  // Clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // Interrupt
  output reg irq_o,
  // Receive path events and status
  input wire frame_drop_i,
  input wire [13:0] rx_fifo_used_i,
  input wire tx_enable_i,
  input wire full_duplex_i,
  input wire speed100_i,
  input wire rx_preamble_i,
  input wire rx_multicast_i,
  input wire rx_broadcast_i,
  input wire rx_own_addr_i,
  // Internal MAC register port
  output reg mac_req_o,
  output reg mac_rd_o,
  output reg [7:0] mac_idx_o,
  output reg [31:0] mac_wdata_o,
  input wire mac_ack_i,
  input wire [31:0] mac_rdata_i,
  // Flow control outputs
  output reg pause_req_o,
  output reg pause_zero_o,
  output reg jam_o
);
  ////////////////////////////////////////////////////////////////////
  // Registers
  reg [31:0] tally;
  reg busy;
  reg dir_rd;
  reg [7:0] idx;
  reg [31:0] mac_data;
  reg [23:0] cfg;
  reg [`RDCB_IRQ_W-1:0] irq_stat;
  reg [`RDCB_IRQ_W-1:0] irq_en;
  reg paused;
  reg above_hi;
  wire jam_active;

  wire wr_tally = wr_i && addr_i == `RDCB_ADDR_TALLY;
  wire rd_tally = rd_i && addr_i == `RDCB_ADDR_TALLY;
  wire wr_cmd = wr_i && addr_i == `RDCB_ADDR_CMD;
  wire wr_data = wr_i && addr_i == `RDCB_ADDR_DATA;
  wire wr_cfg = wr_i && addr_i == `RDCB_ADDR_CFG;
  wire wr_en = wr_i && addr_i == `RDCB_ADDR_IRQ_EN;
  wire wr_clr = wr_i && addr_i == `RDCB_ADDR_IRQ_CLR;

  ////////////////////////////////////////////////////////////////////
  // Dropped frame tally
  wire [31:0] next_tally = tally + 32'h00000001;
  wire half_evt = frame_drop_i && !tally[31] && next_tally[31] && !rd_tally;

  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tally <= `RDCB_RST_ZERO;
    else if (rd_tally)
      tally <= frame_drop_i ? 32'h00000001 : `RDCB_RST_ZERO;
    else if (frame_drop_i)
      tally <= next_tally;
  end

  ////////////////////////////////////////////////////////////////////
  // MAC register bridge
  wire done_evt = busy && mac_ack_i;

  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy <= 1'b0;
      dir_rd <= 1'b0;
      idx <= 8'h00;
      mac_data <= `RDCB_RST_ZERO;
      mac_req_o <= 1'b0;
      mac_rd_o <= 1'b0;
      mac_idx_o <= 8'h00;
      mac_wdata_o <= `RDCB_RST_ZERO;
    end
    else
    begin
      // Writes during busy are ignored; host must wait
      if (wr_cmd && !busy)
      begin
        dir_rd <= wdata_i[`RDCB_CMD_DIR];
        idx <= wdata_i[`RDCB_CMD_IDX_HI:0];
        if (wdata_i[`RDCB_CMD_BUSY])
        begin
          busy <= 1'b1;
          mac_req_o <= 1'b1;
          mac_rd_o <= wdata_i[`RDCB_CMD_DIR];
          mac_idx_o <= wdata_i[`RDCB_CMD_IDX_HI:0];
          mac_wdata_o <= mac_data;
        end
      end
      if (wr_data && !busy)
        mac_data <= wdata_i;
      if (mac_req_o && mac_ack_i)
        mac_req_o <= 1'b0;
      if (done_evt)
      begin
        busy <= 1'b0;
        if (dir_rd)
          mac_data <= mac_rdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Automatic flow control
  wire [13:0] hi_bytes = {cfg[`RDCB_CFG_HI_MSB:`RDCB_CFG_HI_LSB], 6'h00};
  wire [13:0] lo_bytes = {cfg[`RDCB_CFG_LO_MSB:`RDCB_CFG_LO_LSB], 6'h00};
  wire any_en = cfg[`RDCB_CFG_ANY];
  wire fc_en = any_en | cfg[`RDCB_CFG_MULT] | cfg[`RDCB_CFG_BRD] | cfg[`RDCB_CFG_ADDR];
  wire reach_hi = rx_fifo_used_i >= hi_bytes;
  wire match = any_en || (cfg[`RDCB_CFG_MULT] && rx_multicast_i) ||
    (cfg[`RDCB_CFG_BRD] && rx_broadcast_i) || (cfg[`RDCB_CFG_ADDR] && rx_own_addr_i);
  wire jam_start = tx_enable_i && !full_duplex_i && reach_hi && rx_preamble_i &&
    match && !jam_active;

  rdcb_jam_time u_jam
  (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .start_i(jam_start),
    .sel_i(cfg[`RDCB_CFG_DUR_MSB:`RDCB_CFG_DUR_LSB]),
    .speed100_i(speed100_i),
    .active_o(jam_active)
  );

  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg <= 24'h000000;
      paused <= 1'b0;
      above_hi <= 1'b0;
      pause_req_o <= 1'b0;
      pause_zero_o <= 1'b0;
      jam_o <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg <= wdata_i[23:0];
      pause_req_o <= 1'b0;
      pause_zero_o <= 1'b0;
      jam_o <= jam_active && tx_enable_i && !full_duplex_i;
      above_hi <= reach_hi;
      if (tx_enable_i && full_duplex_i && any_en && reach_hi && !above_hi && !paused)
      begin
        pause_req_o <= 1'b1;
        paused <= 1'b1;
      end
      else if (tx_enable_i && fc_en && paused && rx_fifo_used_i < lo_bytes)
      begin
        pause_zero_o <= 1'b1;
        paused <= 1'b0;
      end
      else if (!tx_enable_i)
        paused <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupts; a set in the same cycle as a clear wins
  wire [`RDCB_IRQ_W-1:0] irq_set = {done_evt, half_evt};
  genvar g;
  generate
    for (g = 0; g < `RDCB_IRQ_W; g = g + 1)
    begin : g_irq
      always @(posedge mclk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          irq_stat[g] <= 1'b0;
        else if (irq_set[g])
          irq_stat[g] <= 1'b1;
        else if (wr_clr && wdata_i[g])
          irq_stat[g] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_en <= {`RDCB_IRQ_W{1'b0}};
      irq_o <= 1'b0;
    end
    else
    begin
      if (wr_en)
        irq_en <= wdata_i[`RDCB_IRQ_W-1:0];
      irq_o <= |(irq_stat & irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= `RDCB_RST_ZERO;
    else if (rd_i)
    begin
      case (addr_i)
        `RDCB_ADDR_TALLY: rdata_o <= tally;
        `RDCB_ADDR_CMD: rdata_o <= {busy, dir_rd, 22'h000000, idx};
        `RDCB_ADDR_DATA: rdata_o <= mac_data;
        `RDCB_ADDR_CFG: rdata_o <= {8'h00, cfg};
        `RDCB_ADDR_IRQ_STAT: rdata_o <= {30'h00000000, irq_stat};
        `RDCB_ADDR_IRQ_EN: rdata_o <= {30'h00000000, irq_en};
        default: rdata_o <= `RDCB_RST_ZERO;
      endcase
    end
    else
      rdata_o <= `RDCB_RST_ZERO;
  end
endmodule // rdcb_top

// [test/rdcb_asserts.sv]
`timescale 1ns/1ns
module rdcb_asserts
(
  // Watched ports
  input wire mclk_i,
  input wire rstn_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire tx_enable_i,
  input wire full_duplex_i,
  input wire rx_preamble_i,
  input wire mac_req_o,
  input wire mac_rd_o,
  input wire [7:0] mac_idx_o,
  input wire mac_ack_i,
  input wire pause_req_o,
  input wire pause_zero_o,
  input wire jam_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  reg [31:0] wd_q;
  always @(posedge mclk_i)
    wd_q <= wdata_i;
  ////////////////////////////////////////
  sequence s_go;
    wr_i && addr_i == 8'hA4 && wdata_i[31] && !mac_req_o;
  endsequence
  sequence s_ack;
    mac_req_o && mac_ack_i;
  endsequence
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not idle");
  a_cmd_start: assert property (s_go |=> mac_req_o)
    else $error("no access request");
  a_cmd_fields: assert property (s_go |=> mac_rd_o == wd_q[30] && mac_idx_o == wd_q[7:0])
    else $error("access fields wrong");
  a_req_hold: assert property (mac_req_o && !mac_ack_i |=> mac_req_o)
    else $error("request dropped early");
  a_req_drop: assert property (s_ack |=> !mac_req_o)
    else $error("request not released");
  a_tx_block: assert property (!tx_enable_i && !$past(tx_enable_i) |-> !pause_req_o && !pause_zero_o)
    else $error("pause while transmitter off");
  a_pause_single: assert property (pause_req_o |=> !pause_req_o [*8])
    else $error("repeated pause");
  a_jam_start: assert property ($rose(jam_o) |-> $past(rx_preamble_i, 2) && !$past(full_duplex_i, 2))
    else $error("jam without half duplex frame");
endmodule // rdcb_asserts
bind rdcb_top rdcb_asserts u_chk (.*);

// [test/rdcb_mac_model.sv]
`timescale 1ns/1ns
module rdcb_mac_model
(
  // Clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // Answer delay in cycles
  input wire [3:0] dly_i,
  // Register access port
  input wire req_i,
  input wire rd_i,
  input wire [7:0] idx_i,
  input wire [31:0] wdata_i,
  output reg ack_o,
  output reg [31:0] rdata_o
);
  reg [31:0] mem [0:255];
  reg [3:0] cnt;
  reg done;
  // One ack per request; data toggles every cycle except a read ack cycle
  always @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      cnt <= 4'h0;
      done <= 1'b0;
      ack_o <= 1'b0;
      rdata_o <= 32'h0;
    end
    else
    begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (!req_i)
      begin
        cnt <= 4'h0;
        done <= 1'b0;
      end
      else if (!done && cnt == dly_i)
      begin
        ack_o <= 1'b1;
        done <= 1'b1;
        if (rd_i) rdata_o <= mem[idx_i];
        else mem[idx_i] <= wdata_i;
      end
      else if (!done) cnt <= cnt + 4'h1;
    end
endmodule // rdcb_mac_model

// [test/rx_drop_csr_bridge_flow_cfg_test.sv]
`timescale 1ns/1ns
module rx_drop_csr_bridge_flow_cfg_test;
  reg mclk_i = 0;
  reg rstn_i = 0;
  reg [7:0] addr_i = 0;
  reg [31:0] wdata_i = 0;
  reg wr_i = 0;
  reg rd_i = 0;
  reg frame_drop_i = 0;
  reg [13:0] rx_fifo_used_i = 0;
  reg tx_enable_i = 1;
  reg full_duplex_i = 1;
  reg speed100_i = 1;
  reg rx_preamble_i = 0;
  reg rx_multicast_i = 0;
  reg rx_broadcast_i = 0;
  reg rx_own_addr_i = 0;
  reg [3:0] dly = 6;
  wire [31:0] rdata_o, mac_wdata_o, mac_rdata_i;
  wire irq_o, mac_req_o, mac_rd_o, mac_ack_i, pause_req_o, pause_zero_o, jam_o;
  wire [7:0] mac_idx_o;
  integer fail_count = 0;
  integer checked = 0;
  integer np = 0;
  integer nz = 0;
  integer i;
  reg [31:0] v;
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) np <= np + pause_req_o;
  always @(posedge mclk_i) nz <= nz + pause_zero_o;
  rdcb_top u_dut (.*);
  rdcb_mac_model u_mac (.mclk_i(mclk_i), .rstn_i(rstn_i), .dly_i(dly), .req_i(mac_req_o),
    .rd_i(mac_rd_o), .idx_i(mac_idx_o), .wdata_i(mac_wdata_o), .ack_o(mac_ack_i),
    .rdata_o(mac_rdata_i));
  ////////////////////////////////////////
  task chk(input [31:0] s, input [31:0] e);
  begin
    checked = checked + 1;
    if (s !== e)
    begin
      fail_count = fail_count + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge mclk_i);
    wr_i <= 0;
  end
  endtask
  task rd(input [7:0] a, output [31:0] d);
  begin
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge mclk_i);
    rd_i <= 0;
    @(posedge mclk_i);
    d = rdata_o;
  end
  endtask
  task rc(input [7:0] a, input [31:0] e);
  begin
    rd(a, v);
    chk(v, e);
  end
  endtask
  task idle;
  begin
    v = 32'h80000000;
    for (i = 0; i < 40 && v[31] !== 1'b0; i = i + 1)
      rd(8'hA4, v);
    chk(v[31], 0);
  end
  endtask
  task step(input [13:0] f);
  begin
    rx_fifo_used_i <= f;
    repeat (20) @(posedge mclk_i);
  end
  endtask
  task pre;
  begin
    @(posedge mclk_i);
    rx_preamble_i <= 1;
    @(posedge mclk_i);
    rx_preamble_i <= 0;
  end
  endtask
  task end_sim;
  begin
    $display("Checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    end_sim;
  end
  initial
  begin
    repeat (6) @(posedge mclk_i);
    rstn_i <= 1;
    rc(8'hA0, 0);
    rc(8'hA8, 0);
    rc(8'hAC, 0);
    rc(8'h40, 0);
    frame_drop_i <= 1;
    repeat (3) @(posedge mclk_i);
    frame_drop_i <= 0;
    rc(8'hA0, 3);
    rc(8'hA0, 0);
    wr(8'hB8, 2);
    wr(8'hA8, 32'hDEADBEEF);
    wr(8'hA4, 32'h80000012);
    wr(8'hA8, 32'h00000001);
    idle;
    chk(irq_o, 1);
    rc(8'hB4, 2);
    rc(8'hA8, 32'hDEADBEEF);
    wr(8'hBC, 2);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 0);
    wr(8'hB8, 0);
    dly <= 0;
    wr(8'hA4, 32'hC0000012);
    idle;
    chk(irq_o, 0);
    rc(8'hB4, 2);
    rc(8'hA8, 32'hDEADBEEF);
    wr(8'hAC, 32'h00020101);
    rc(8'hAC, 32'h00020101);
    step(127);
    chk(np, 0);
    step(128);
    chk(np, 1);
    step(200);
    chk(np, 1);
    step(64);
    chk(nz, 0);
    step(63);
    chk(nz, 1);
    step(100);
    step(10);
    chk(nz, 1);
    tx_enable_i <= 0;
    step(200);
    chk(np, 1);
    tx_enable_i <= 1;
    full_duplex_i <= 0;
    wr(8'hAC, 32'h00020008);
    rx_broadcast_i <= 1;
    pre;
    repeat (10) @(posedge mclk_i);
    chk(jam_o, 0);
    rx_multicast_i <= 1;
    pre;
    repeat (100) @(posedge mclk_i);
    chk(jam_o, 1);
    repeat (148) @(posedge mclk_i);
    chk(jam_o, 1);
    repeat (4) @(posedge mclk_i);
    chk(jam_o, 0);
    chk(np, 1);
    end_sim;
  end
endmodule // rx_drop_csr_bridge_flow_cfg_test
